// ---- logic/ids_consts.svh ----
`ifndef IDS_CONSTS_SVH
`define IDS_CONSTS_SVH

////////////////////////////////////////////////////////////////////////////////
// register byte offsets (avalon byte address bits [3:0])
`define IDS_OFF_EXT        4'h0
`define IDS_OFF_FLAGS      4'h4
`define IDS_OFF_IRQ_STS    4'h8
`define IDS_OFF_IRQ_MASK   4'hC

////////////////////////////////////////////////////////////////////////////////
// field positions
`define IDS_FLD_QFLAG      0
`define IDS_FLD_NEG        1
`define IDS_EVT_SIGNED     0
`define IDS_EVT_UNSIGNED   1
`define IDS_EVT_REM_DONE   2
`define IDS_NUM_EVT        3
`define IDS_LIT_W          8
`define IDS_DATA_W         32
`define IDS_REG_NUM_W      8

////////////////////////////////////////////////////////////////////////////////
// reset values
`define IDS_RST_EXT        32'h0000_0000
`define IDS_RST_QFLAG      1'b0
`define IDS_RST_NEG        1'b0
`define IDS_RST_MASK       3'h0

////////////////////////////////////////////////////////////////////////////////
// timing counts in clk_sys_in cycles
`define IDS_RESULT_LAT     1
`define IDS_BUS_LAT        2

`endif

// ---- logic/ids_pkg.sv ----
package ids_pkg;

  // operation presented by the decode stage
  typedef enum logic [2:0] {
    IDS_OP_NONE               = 3'h0,
    QUOTIENT_STEP_OP          = 3'h1,
    QUOTIENT_SETUP_OP         = 3'h2,
    QUOTIENT_FINAL_OP         = 3'h3,
    REMAINDER_FIX_OP          = 3'h4,
    SIGNED_LONG_QUOTIENT_OP   = 3'h5,
    UNSIGNED_LONG_QUOTIENT_OP = 3'h6
  } ids_op_e;

  // avalon slave answer state, one-hot
  typedef enum logic [1:0] {
    IDS_BUS_WAIT = 2'b01,
    IDS_BUS_ACK  = 2'b10
  } ids_bus_e;

  typedef struct packed {
    logic [31:0] ext;
    logic        qflag;
    logic        neg;
    logic        res_valid;
    logic [31:0] res_data;
    logic [7:0]  res_reg;
    logic        trap_valid;
    logic [1:0]  trap_kind;
    logic [7:0]  ptr_a;
    logic [7:0]  ptr_b;
    logic [7:0]  ptr_c;
    logic [2:0]  irq_sts;
    logic [2:0]  irq_mask;
    logic        irq;
    ids_bus_e    bus_st;
    logic        waitreq;
    logic [31:0] rdata;
  } ids_state_s;

endpackage

// ---- logic/ids_addsub.sv ----
`timescale 1ns/1ps
module ids_addsub
(
  input  wire logic [31:0] a_in,    // first operand
  input  wire logic [31:0] b_in,    // second operand
  input  wire logic        sub_in,  // 1: a - b, 0: a + b
  output logic      [31:0] sum_out, // result
  output logic             cout_out // carry out of bit 31
);

  logic [31:0] b_eff;

  // subtract as a + ~b + 1 so the carry keeps its adder meaning
  assign b_eff = sub_in ? ~b_in : b_in;
  assign {cout_out, sum_out} = {1'b0, a_in} + {1'b0, b_eff} + {32'h0000_0000, sub_in};

endmodule

// ---- logic/ids_shift64.sv ----
`timescale 1ns/1ps
module ids_shift64
(
  input  wire logic [31:0] hi_in,  // upper word
  input  wire logic [31:0] lo_in,  // lower word
  input  wire logic        fill_in,// bit entering position 0
  output logic      [31:0] hi_out, // upper word after shift
  output logic      [31:0] lo_out  // lower word after shift
);

  assign {hi_out, lo_out} = {hi_in[30:0], lo_in, fill_in};

endmodule

// ---- logic/ids_divide_step_unit.sv ----
// Notes on behaviour
// - step subtracts second operand when flag is 1, adds when 0
// - new flag is not(carry xor old flag xor top bit); top bit takes sum sign
// - step shifts sum and extension left, new flag enters bit zero
// - literal-select picks register or zero-extended 8-bit literal as second operand
// - setup sets flag to one, top bit takes sign of second operand
// - setup shifts second operand and extension left with zero entering
// - final step adds or subtracts like a step, writes unshifted sum, updates flags
// - final step shifts extension alone left, new flag entering bit zero
// - remainder fix writes first operand when flag is 1, else the sum
// - signed long divide traps, loading pointers to sources and destination
// - unsigned long divide traps distinctly, loading the same three pointers
//
// Design decisions made here: the address map and the Avalon-MM slave port.
`timescale 1ns/1ps
`include "ids_consts.svh"
module ids_divide_step_unit
  import ids_pkg::*;
(
  input  wire logic        clk_sys_in,                 // core clock, 200 MHz
  input  wire logic        arst_n_in,                  // async reset, active low
  input  wire logic        issue_valid_in,             // operation issued this cycle
  input  wire ids_op_e     op_in,                      // operation code
  input  wire logic [31:0] first_operand_in,           // first source value
  input  wire logic [31:0] second_operand_in,          // second source register value
  input  wire logic [7:0]  literal_in,                 // instruction literal
  input  wire logic        literal_sel_in,             // 1: use literal as second source
  input  wire logic [7:0]  first_operand_num_in,       // first source register number
  input  wire logic [7:0]  second_operand_num_in,      // second source register number
  input  wire logic [7:0]  result_target_num_in,       // destination register number
  output logic             result_valid_out,           // write-back strobe
  output logic      [31:0] result_data_out,            // write-back value
  output logic      [7:0]  result_target_out,          // write-back register number
  output logic             trap_valid_out,             // trap strobe
  output logic      [1:0]  trap_kind_out,              // bit0 signed, bit1 unsigned
  output logic      [7:0]  trap_operand_a_pointer_out, // first source reference
  output logic      [7:0]  trap_operand_b_pointer_out, // second source reference
  output logic      [7:0]  trap_result_pointer_out,    // destination reference
  output logic             quotient_step_flag_out,     // current flag
  output logic             irq_out,                    // level interrupt
  input  wire logic [3:0]  avs_address_in,             // byte address
  input  wire logic        avs_read_in,                // read request
  input  wire logic        avs_write_in,               // write request
  input  wire logic [31:0] avs_writedata_in,           // write data
  input  wire logic [3:0]  avs_byteenable_in,          // byte lanes
  output logic      [31:0] avs_readdata_out,           // read data
  output logic             avs_waitrequest_out         // stall
);

  //////////////////////////////////////////////////////////////////////////////
  // register decode, one-hot: ext, flags, status, mask

  function automatic logic [3:0] reg_sel(input logic [3:0] addr);
    logic [3:0] sel;
    sel = 4'h0;
    case (addr)
      `IDS_OFF_EXT:      sel = 4'h1;
      `IDS_OFF_FLAGS:    sel = 4'h2;
      `IDS_OFF_IRQ_STS:  sel = 4'h4;
      `IDS_OFF_IRQ_MASK: sel = 4'h8;
      default:           sel = 4'h0;
    endcase
    return sel;
  endfunction

  ids_state_s  st_q;
  ids_state_s  st_d;
  logic [31:0] be_mask;
  logic [31:0] opnd_b;
  logic [31:0] sum;
  logic        cout;
  logic        new_qflag;
  logic [31:0] sh_hi;
  logic [31:0] sh_lo;
  logic        is_setup;
  logic [3:0]  sel;
  logic [31:0] rd_mux;
  logic [2:0]  events;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1)
    begin : g_be
      assign be_mask[gi*8 +: 8] = {8{avs_byteenable_in[gi]}};
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // datapath

  assign opnd_b    = literal_sel_in ? {24'h00_0000, literal_in} : second_operand_in;
  assign is_setup  = (op_in == QUOTIENT_SETUP_OP);
  assign new_qflag = ~(cout ^ st_q.qflag ^ st_q.neg);
  assign sel      = reg_sel(avs_address_in);

  ids_addsub u_addsub
  (
    .a_in     (first_operand_in),
    .b_in     (opnd_b),
    .sub_in   (st_q.qflag),
    .sum_out  (sum),
    .cout_out (cout)
  );

  // setup shifts the second operand with zero fill, steps shift the sum
  ids_shift64 u_shift
  (
    .hi_in   (is_setup ? opnd_b : sum),
    .lo_in   (st_q.ext),
    .fill_in (is_setup ? 1'b0 : new_qflag),
    .hi_out  (sh_hi),
    .lo_out  (sh_lo)
  );

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (sel)
      4'h1:    rd_mux = st_q.ext;
      4'h2:    rd_mux = {30'h0, st_q.neg, st_q.qflag};
      4'h4:    rd_mux = {29'h0, st_q.irq_sts};
      4'h8:    rd_mux = {29'h0, st_q.irq_mask};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb
  begin
    st_d            = st_q;
    st_d.res_valid  = 1'b0;
    st_d.trap_valid = 1'b0;
    events          = 3'h0;

    // bus slave: request seen, answer one cycle later
    case (st_q.bus_st)
      IDS_BUS_WAIT:
      begin
        if (avs_read_in || avs_write_in)
        begin
          st_d.bus_st  = IDS_BUS_ACK;
          st_d.waitreq = 1'b0;
          st_d.rdata   = avs_read_in ? rd_mux : 32'h0000_0000;
        end
      end
      IDS_BUS_ACK:
      begin
        st_d.bus_st  = IDS_BUS_WAIT;
        st_d.waitreq = 1'b1;
        if (avs_write_in)
        begin
          if (sel[0])
            st_d.ext = (st_q.ext & ~be_mask) | (avs_writedata_in & be_mask);
          if (sel[1] && avs_byteenable_in[0])
          begin
            st_d.qflag = avs_writedata_in[`IDS_FLD_QFLAG];
            st_d.neg = avs_writedata_in[`IDS_FLD_NEG];
          end
          if (sel[3] && avs_byteenable_in[0])
            st_d.irq_mask = avs_writedata_in[2:0];
        end
        // clear only what the read reported
        if (avs_read_in && sel[2])
          st_d.irq_sts = st_q.irq_sts & ~st_q.rdata[2:0];
      end
      default:
      begin
        st_d.bus_st  = IDS_BUS_WAIT;
        st_d.waitreq = 1'b1;
      end
    endcase

    // instruction execution has priority over a bus write in the same cycle
    if (issue_valid_in)
    begin
      st_d.res_reg = result_target_num_in;
      case (op_in)
        QUOTIENT_STEP_OP:
        begin
          st_d.res_valid = 1'b1;
          st_d.res_data  = sh_hi;
          st_d.ext       = sh_lo;
          st_d.qflag     = new_qflag;
          st_d.neg       = sum[31];
        end
        QUOTIENT_SETUP_OP:
        begin
          st_d.res_valid = 1'b1;
          st_d.res_data  = sh_hi;
          st_d.ext       = sh_lo;
          st_d.qflag     = 1'b1;
          st_d.neg       = opnd_b[31];
        end
        QUOTIENT_FINAL_OP:
        begin
          st_d.res_valid = 1'b1;
          st_d.res_data  = sum;
          st_d.ext       = sh_lo;
          st_d.qflag     = new_qflag;
          st_d.neg       = sum[31];
        end
        REMAINDER_FIX_OP:
        begin
          st_d.res_valid = 1'b1;
          st_d.res_data  = st_q.qflag ? first_operand_in : sum;
          events[`IDS_EVT_REM_DONE] = 1'b1;
        end
        SIGNED_LONG_QUOTIENT_OP:
        begin
          st_d.trap_valid = 1'b1;
          st_d.trap_kind  = 2'b01;
          st_d.ptr_a      = first_operand_num_in;
          st_d.ptr_b      = second_operand_num_in;
          st_d.ptr_c      = result_target_num_in;
          events[`IDS_EVT_SIGNED] = 1'b1;
        end
        UNSIGNED_LONG_QUOTIENT_OP:
        begin
          st_d.trap_valid = 1'b1;
          st_d.trap_kind  = 2'b10;
          st_d.ptr_a      = first_operand_num_in;
          st_d.ptr_b      = second_operand_num_in;
          st_d.ptr_c      = result_target_num_in;
          events[`IDS_EVT_UNSIGNED] = 1'b1;
        end
        default:
        begin
          st_d.res_reg = st_q.res_reg;
        end
      endcase
    end

    // a new event wins over the read clear
    st_d.irq_sts = st_d.irq_sts | events;
    st_d.irq     = |(st_d.irq_sts & st_d.irq_mask);
  end

  always_ff @(posedge clk_sys_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      st_q            <= '0;
      st_q.ext        <= `IDS_RST_EXT;
      st_q.qflag      <= `IDS_RST_QFLAG;
      st_q.neg        <= `IDS_RST_NEG;
      st_q.irq_mask   <= `IDS_RST_MASK;
      st_q.bus_st     <= IDS_BUS_WAIT;
      st_q.waitreq    <= 1'b1;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs

  assign result_valid_out           = st_q.res_valid;
  assign result_data_out            = st_q.res_data;
  assign result_target_out          = st_q.res_reg;
  assign trap_valid_out             = st_q.trap_valid;
  assign trap_kind_out              = st_q.trap_kind;
  assign trap_operand_a_pointer_out = st_q.ptr_a;
  assign trap_operand_b_pointer_out = st_q.ptr_b;
  assign trap_result_pointer_out    = st_q.ptr_c;
  assign quotient_step_flag_out     = st_q.qflag;
  assign irq_out                    = st_q.irq;
  assign avs_readdata_out           = st_q.rdata;
  assign avs_waitrequest_out        = st_q.waitreq;

  //////////////////////////////////////////////////////////////////////////////
  // checks, computed from the ports and st_q independently of the datapath

  logic [31:0] chk_b;
  logic [32:0] chk_sub;
  logic [32:0] chk_add;
  logic        chk_cout;
  logic [31:0] chk_step_result_target;
  logic [31:0] chk_setup_result_target;
  logic [30:0] chk_ext_lo;
  logic        chk_is_div;
  logic        chk_is_fin;

  assign chk_b          = literal_sel_in ? {24'h00_0000, literal_in} : second_operand_in;
  assign chk_sub        = {1'b0, first_operand_in} - {1'b0, chk_b};
  assign chk_add        = {1'b0, first_operand_in} + {1'b0, chk_b};
  assign chk_cout       = st_q.qflag ? ~chk_sub[32] : chk_add[32];
  assign chk_step_result_target  = {(st_q.qflag ? chk_sub[30:0] : chk_add[30:0]), st_q.ext[31]};
  assign chk_setup_result_target = {chk_b[30:0], st_q.ext[31]};
  assign chk_ext_lo     = st_q.ext[30:0];
  assign chk_is_div     = issue_valid_in && (op_in == QUOTIENT_STEP_OP);
  assign chk_is_fin     = issue_valid_in && (op_in == QUOTIENT_FINAL_OP);

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!arst_n_in);

  sequence s_trap_load;
    trap_valid_out
    && trap_operand_a_pointer_out == $past(first_operand_num_in)
    && trap_operand_b_pointer_out == $past(second_operand_num_in)
    && trap_result_pointer_out == $past(result_target_num_in)
    && !result_valid_out;
  endsequence

  sequence s_flag_update;
    quotient_step_flag_out == ~($past(chk_cout) ^ $past(st_q.qflag) ^ $past(st_q.neg));
  endsequence

  a_step_sub_add: assert property (
    chk_is_div |=> result_valid_out && result_data_out == $past(chk_step_result_target))
    else $error("divide step result wrong");

  a_flag_update: assert property (
    (chk_is_div || chk_is_fin) |=> s_flag_update
      ##0 st_q.neg == $past(st_q.qflag ? chk_sub[31] : chk_add[31]))
    else $error("divide flag or top bit wrong");

  a_step_ext_shift: assert property (
    chk_is_div |=> st_q.ext[31:1] == $past(chk_ext_lo) && st_q.ext[0] == st_q.qflag)
    else $error("step extension shift wrong");

  a_literal_sel: assert property (
    issue_valid_in && op_in == QUOTIENT_SETUP_OP && literal_sel_in
      |=> !st_q.neg && result_data_out[31:9] == 23'h00_0000)
    else $error("literal not zero-extended");

  a_setup_flags: assert property (
    issue_valid_in && op_in == QUOTIENT_SETUP_OP
      |=> quotient_step_flag_out && st_q.neg == $past(chk_b[31]))
    else $error("setup flags wrong");

  a_setup_shift: assert property (
    issue_valid_in && op_in == QUOTIENT_SETUP_OP
      |=> result_data_out == $past(chk_setup_result_target) && !st_q.ext[0]
          && st_q.ext[31:1] == $past(chk_ext_lo))
    else $error("setup shift wrong");

  a_final_sum: assert property (
    chk_is_fin && !st_q.qflag |=> result_data_out == $past(chk_add[31:0])
      && st_q.neg == result_data_out[31])
    else $error("final step sum wrong");

  a_final_ext: assert property (
    chk_is_fin |=> st_q.ext == {$past(chk_ext_lo), quotient_step_flag_out})
    else $error("final step extension wrong");

  a_rem_fix: assert property (
    issue_valid_in && op_in == REMAINDER_FIX_OP
      |=> result_valid_out && result_data_out ==
          ($past(st_q.qflag) ? $past(first_operand_in) : $past(chk_add[31:0])))
    else $error("remainder fix wrong");

  a_signed_trap: assert property (
    issue_valid_in && op_in == SIGNED_LONG_QUOTIENT_OP
      |=> s_trap_load ##0 trap_kind_out == 2'b01 ##1 !trap_valid_out
          || $past(issue_valid_in))
    else $error("signed divide trap wrong");

  a_unsigned_trap: assert property (
    issue_valid_in && op_in == UNSIGNED_LONG_QUOTIENT_OP
      |=> s_trap_load ##0 trap_kind_out == 2'b10 && st_q.irq_sts[`IDS_EVT_UNSIGNED])
    else $error("unsigned divide trap wrong");

  a_bus_answer: assert property (
    $rose(avs_read_in) && avs_waitrequest_out |=> !avs_waitrequest_out ##1 avs_waitrequest_out)
    else $error("bus answer timing wrong");

endmodule

// ---- sim/ids_decode_model.sv ----
`timescale 1ns/1ps
module ids_decode_model
  import ids_pkg::*;
(
  input  wire logic        clk_sys_in,       // core clock
  output logic             issue_valid_out,  // op issued
  output ids_op_e          op_out,           // op code
  output logic      [31:0] first_out,        // first source value
  output logic      [31:0] second_out,       // second source value
  output logic      [7:0]  literal_out,      // instruction literal
  output logic             literal_sel_out,  // literal select
  output logic      [7:0]  num_a_out,        // first source number
  output logic      [7:0]  num_b_out,        // second source number
  output logic      [7:0]  num_c_out,        // destination number
  input  wire logic        result_valid_in,  // write-back strobe
  input  wire logic [31:0] result_data_in,   // write-back value
  input  wire logic [7:0]  result_target_in, // write-back number
  input  wire logic        trap_valid_in     // trap strobe
);
  logic [31:0] rf [256];

  initial
  begin
    issue_valid_out = 1'b0;
    op_out = IDS_OP_NONE;
    {first_out, second_out, literal_out, literal_sel_out} = '0;
    {num_a_out, num_b_out, num_c_out} = '0;
  end

  ////////////////////////////////////////////////////////////
  // one op at a time: the next op reads what the last one wrote
  task automatic issue(input ids_op_e op, input logic [7:0] ra, input logic [7:0] rb,
                       input logic [7:0] rc, input logic [7:0] lit, input logic sel,
                       output logic got);
    int n;
    begin
      got = 1'b0;
      @(posedge clk_sys_in);
      issue_valid_out <= 1'b1;
      op_out <= op;
      first_out <= rf[ra];
      second_out <= rf[rb];
      literal_out <= lit;
      literal_sel_out <= sel;
      {num_a_out, num_b_out, num_c_out} <= {ra, rb, rc};
      @(posedge clk_sys_in);
      issue_valid_out <= 1'b0;
      op_out <= IDS_OP_NONE;
      first_out <= ~rf[ra];
      second_out <= ~rf[rb];
      literal_out <= ~lit;
      for (n = 0; n < 4 && !got; n++)
      begin
        @(posedge clk_sys_in);
        got = (result_valid_in === 1'b1) || (trap_valid_in === 1'b1);
        if (result_valid_in === 1'b1)
          rf[result_target_in] = result_data_in;
      end
    end
  endtask
endmodule

// ---- sim/integer_divide_step_unit_tb.sv ----
`timescale 1ns/1ps
module integer_divide_step_unit_tb;
  import ids_pkg::*;
  logic        clk_sys_in;
  logic        arst_n_in;
  logic        iv;
  ids_op_e     op;
  logic [31:0] fa;
  logic [31:0] fb;
  logic [7:0]  lit;
  logic        lsel;
  logic [7:0]  na;
  logic [7:0]  nb;
  logic [7:0]  nc;
  logic        rv;
  logic [31:0] rd;
  logic [7:0]  rt;
  logic        tv;
  logic [1:0]  tk;
  logic [7:0]  pa;
  logic [7:0]  pb;
  logic [7:0]  pc;
  logic        dfo;
  logic        irq;
  logic [3:0]  avs_address_in;
  logic        avs_read_in;
  logic        avs_write_in;
  logic [31:0] avs_writedata_in;
  logic [31:0] avs_readdata_out;
  logic        avs_waitrequest_out;
  logic [31:0] m_ext;
  logic        m_qflag;
  logic        m_neg;
  logic [2:0]  m_sts;
  logic [2:0]  m_mask;
  logic [31:0] d;
  logic [31:0] dvd;
  logic [31:0] dvs;
  int          fail_count;
  int          n_checks;

  initial
  begin
    clk_sys_in = 1'b0;
    forever #2.5 clk_sys_in = ~clk_sys_in;
  end

  ids_decode_model p (.clk_sys_in(clk_sys_in), .issue_valid_out(iv), .op_out(op),
    .first_out(fa), .second_out(fb), .literal_out(lit), .literal_sel_out(lsel),
    .num_a_out(na), .num_b_out(nb), .num_c_out(nc), .result_valid_in(rv),
    .result_data_in(rd), .result_target_in(rt), .trap_valid_in(tv));

  ids_divide_step_unit dut (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in),
    .issue_valid_in(iv), .op_in(op), .first_operand_in(fa), .second_operand_in(fb),
    .literal_in(lit), .literal_sel_in(lsel), .first_operand_num_in(na),
    .second_operand_num_in(nb), .result_target_num_in(nc), .result_valid_out(rv),
    .result_data_out(rd), .result_target_out(rt), .trap_valid_out(tv), .trap_kind_out(tk),
    .trap_operand_a_pointer_out(pa), .trap_operand_b_pointer_out(pb),
    .trap_result_pointer_out(pc), .quotient_step_flag_out(dfo), .irq_out(irq),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_byteenable_in(4'hF), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out));

  ////////////////////////////////////////////////////////////
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd,
                     output logic [31:0] r);
    int n;
    begin
      @(posedge clk_sys_in);
      avs_address_in <= a;
      avs_writedata_in <= wd;
      avs_write_in <= wr;
      avs_read_in <= !wr;
      n = 0;
      @(posedge clk_sys_in);
      while (avs_waitrequest_out !== 1'b0 && n < 20)
      begin
        n++;
        @(posedge clk_sys_in);
      end
      r = avs_readdata_out;
      avs_read_in <= 1'b0;
      avs_write_in <= 1'b0;
      if (n >= 20)
      begin
        fail_count++;
        give_verdict;
      end
    end
  endtask

  ////////////////////////////////////////////////////////////
  task automatic run_op(input ids_op_e o, input logic [7:0] ra, input logic [7:0] rb,
                        input logic [7:0] rc, input logic [7:0] li, input logic sel);
    logic [31:0] a;
    logic [31:0] b;
    logic [32:0] t;
    logic        nd;
    logic        got;
    begin
      a = p.rf[ra];
      b = sel ? {24'h000000, li} : p.rf[rb];
      t = m_qflag ? {1'b0, a} + {1'b0, ~b} + 33'h1 : {1'b0, a} + {1'b0, b};
      nd = ~(t[32] ^ m_qflag ^ m_neg);
      p.issue(o, ra, rb, rc, li, sel, got);
      chk("strobe", {31'h0, (o != IDS_OP_NONE && o <= UNSIGNED_LONG_QUOTIENT_OP)},
          {31'h0, got});
      case (o)
        QUOTIENT_STEP_OP: chk("step", {t[30:0], m_ext[31]}, rd);
        QUOTIENT_SETUP_OP: chk("setup", {b[30:0], m_ext[31]}, rd);
        QUOTIENT_FINAL_OP: chk("final", t[31:0], rd);
        REMAINDER_FIX_OP: chk("remfix", m_qflag ? a : a + b, rd);
        SIGNED_LONG_QUOTIENT_OP: chk("trap kind", 32'h1, {30'h0, tk});
        UNSIGNED_LONG_QUOTIENT_OP: chk("trap kind", 32'h2, {30'h0, tk});
        default: ;
      endcase
      if (o >= SIGNED_LONG_QUOTIENT_OP && o <= UNSIGNED_LONG_QUOTIENT_OP)
      begin
        chk("pointers", {8'h00, ra, rb, rc}, {8'h00, pa, pb, pc});
        m_sts = m_sts | ((o == SIGNED_LONG_QUOTIENT_OP) ? 3'h1 : 3'h2);
      end
      if (o == REMAINDER_FIX_OP)
        m_sts[2] = 1'b1;
      if (o == QUOTIENT_STEP_OP || o == QUOTIENT_FINAL_OP)
      begin
        m_ext = {m_ext[30:0], nd};
        m_qflag = nd;
        m_neg = t[31];
      end
      if (o == QUOTIENT_SETUP_OP)
      begin
        m_ext = {m_ext[30:0], 1'b0};
        m_qflag = 1'b1;
        m_neg = b[31];
      end
      if (o >= QUOTIENT_STEP_OP && o <= REMAINDER_FIX_OP)
        chk("target", {24'h000000, rc}, {24'h000000, rt});
      chk("flag", {31'h0, m_qflag}, {31'h0, dfo});
      bus(1'b0, 4'h4, 32'h0, d);
      chk("flags reg", {30'h0, m_neg, m_qflag}, d);
      bus(1'b0, 4'h0, 32'h0, d);
      chk("ext reg", m_ext, d);
    end
  endtask

  ////////////////////////////////////////////////////////////
  initial
  begin
    {arst_n_in, avs_address_in, avs_read_in, avs_write_in, avs_writedata_in} = '0;
    {m_ext, m_qflag, m_neg, m_sts, m_mask, fail_count, n_checks} = '0;
    void'($urandom(48307));
    repeat (10) @(posedge clk_sys_in);
    arst_n_in <= 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      bus(1'b0, 4'(i * 4), 32'h0, d);
      chk("reset reg", 32'h0, d);
    end
    $display("test reset values done");
    for (int k = 0; k < 4; k++)
    begin
      dvd = (k == 0) ? 32'hFFFF_FFFF : (k == 3) ? 32'h5 : $urandom;
      dvs = k[0] ? ($urandom % 255) + 1 : ($urandom & 32'h7FFF_FFFF) | 32'h1;
      if (k == 3)
        dvs = 32'h7;
      bus(1'b1, 4'h0, dvd, d);
      m_ext = dvd;
      p.rf[1] = 32'h0;
      p.rf[2] = dvs;
      run_op(QUOTIENT_SETUP_OP, 8'h03, 8'h01, 8'h03, 8'h00, k[0]);
      repeat (31) run_op(QUOTIENT_STEP_OP, 8'h03, 8'h02, 8'h03, dvs[7:0], k[0]);
      run_op(QUOTIENT_FINAL_OP, 8'h03, 8'h02, 8'h03, dvs[7:0], k[0]);
      run_op(REMAINDER_FIX_OP, 8'h03, 8'h02, 8'h04, dvs[7:0], k[0]);
      chk("quotient", dvd / dvs, d);
      chk("remainder", dvd % dvs, p.rf[4]);
      $display("test division %0d done", k);
    end
    run_op(SIGNED_LONG_QUOTIENT_OP, 8'h11, 8'h22, 8'h33, 8'h00, 1'b0);
    run_op(UNSIGNED_LONG_QUOTIENT_OP, 8'hA5, 8'h5A, 8'hC3, 8'h00, 1'b1);
    run_op(IDS_OP_NONE, 8'h01, 8'h02, 8'h05, 8'h00, 1'b0);
    run_op(ids_op_e'(3'h7), 8'h01, 8'h02, 8'h05, 8'h00, 1'b0);
    $display("test traps and ignored ops done");
    for (int m = 0; m < 8; m++)
    begin
      m_mask = 3'(m);
      bus(1'b1, 4'hC, {29'h0, m_mask}, d);
      repeat (2) @(posedge clk_sys_in);
      chk("irq", {31'h0, |(m_sts & m_mask)}, {31'h0, irq});
    end
    bus(1'b0, 4'h8, 32'h0, d);
    chk("status", {29'h0, m_sts}, d);
    repeat (2) @(posedge clk_sys_in);
    chk("irq cleared", 32'h0, {31'h0, irq});
    bus(1'b0, 4'h8, 32'h0, d);
    chk("status cleared", 32'h0, d);
    bus(1'b1, 4'h2, 32'hFFFF_FFFF, d);
    bus(1'b0, 4'h2, 32'h0, d);
    chk("unmapped", 32'h0, d);
    bus(1'b0, 4'hC, 32'h0, d);
    chk("mask", {29'h0, m_mask}, d);
    $display("test interrupt and bus done");
    give_verdict;
  end
endmodule
